// [adc_cfg_pkg.sv]
package adc_cfg_pkg;
  // register indices on the register port
  localparam logic [7:0] STATUS_ADDR = 8'h01;
  localparam logic [7:0] MODE_ADDR = 8'h02;
  localparam logic [7:0] CLOCK_ADDR = 8'h03;
  localparam logic [7:0] GAIN_ADDR = 8'h04;
  localparam logic [7:0] RSVD5_ADDR = 8'h05;
  localparam logic [7:0] CHOP_ADDR = 8'h06;
  // reset values
  localparam logic [15:0] MODE_RST = 16'h0510;
  localparam logic [15:0] CLOCK_RST = 16'h038e;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] RSVD5_RST = 16'h0000;
  localparam logic [15:0] CHOP_RST = 16'h0600;
  // writable bit masks
  localparam logic [15:0] MODE_WMASK = 16'hffff;
  localparam logic [15:0] CLOCK_WMASK = 16'h03ff;
  localparam logic [15:0] GAIN_WMASK = 16'hffff;
  localparam logic [15:0] CHOP_WMASK = 16'hffff;
  // mode field positions
  localparam int MODE_REGCRC_BIT = 13;
  localparam int MODE_RXCRC_BIT = 12;
  localparam int MODE_CRCTYPE_BIT = 11;
  localparam int MODE_RESET_BIT = 10;
  localparam int MODE_WLEN_LSB = 8;
  localparam int MODE_TIMEOUT_BIT = 4;
  localparam int MODE_FLOAT_BIT = 1;
  // clock field positions
  localparam int CLK_CH1_BIT = 9;
  localparam int CLK_CH0_BIT = 8;
  localparam int CLK_SEL_BIT = 7;
  localparam int CLK_OSR_LSB = 2;
  localparam int CLK_PWR_LSB = 0;
  // gain and chop field positions
  localparam int GAIN1_LSB = 4;
  localparam int GAIN0_LSB = 0;
  localparam int CHOP_DLY_LSB = 9;
  localparam int CHOP_EN_BIT = 8;
  // status field positions
  localparam int STAT_CRCTYPE_BIT = 11;
  localparam int STAT_RESET_BIT = 10;
  localparam int STAT_WLEN_LSB = 8;
  // register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
  // decoded settings handed to the converter
  typedef struct packed {
    logic [1:0] word_length_select;
    logic timeout_enable;
    logic ready_pin_idle_float;
    logic reg_crc_enable;
    logic rx_crc_enable;
    logic crc_type_ansi;
    logic second_channel_enable;
    logic first_channel_enable;
    logic ext_clock_select;
    logic [2:0] oversample_ratio_code;
    logic [1:0] power_mode_code;
    logic [2:0] second_channel_gain;
    logic [2:0] first_channel_gain;
    logic [3:0] chop_delay_code;
    logic chop_enable;
  } adc_cfg_t;
endpackage

// [adc_config_register_bank.sv]
`timescale 1ns/1ps
// Functional notes
// R1: reset flag set; mode write zero clears
// R2: word length 16/24/32pad/32sign select
// R3: serial timeout enable resets to one
// R4: idle ready pin high or floating
// R5: clock bit 9 enables second channel
// R6: clock bit 8 enables first channel
// R7: clock bit 7 selects external clock
// R8: oversampling ratio is 128 times two^code
// R9: power mode code, reset high resolution
// R10: gain bits 6:4 second channel gain
// R11: gain bits 2:0 first channel gain
// R12: clock register resets to 038Eh
// R13: status mirrors word length and reset flag
// R14: mode holds crc enables and type
// R15: chop delay code, default sixteen periods
// R16: chop enable bit 8, reset disabled
// R17: host writes reserved zero; read-only ignored
// R18: settings apply at next conversion start; the ready pin follows the mode float bit at once
module adc_config_register_bank
  import adc_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire reg_req_t req, // register read/write request
  output logic [15:0] rdata_ff, // read data, registered
  output logic rvalid_ff, // read answer strobe
  input wire logic conv_start, // converter begins a conversion
  input wire logic [1:0] new_data, // per-channel data available
  output adc_cfg_t cfg_ff, // settings latched at conversion start
  output logic [15:0] osr_ratio_ff, // decoded oversampling ratio
  output logic data_ready_out, // ready pin output level
  output logic data_ready_oe // ready pin output enable
);
  // register storage
  logic [15:0] mode_ff;
  logic [15:0] clock_ff;
  logic [15:0] gain_ff;
  logic [15:0] rsvd5_ff;
  logic [15:0] chop_ff;
  logic reset_flag_ff; // sticky reset indicator
  adc_cfg_t nxt_cfg;
  logic [15:0] status_w;
  logic any_new;

  // masked write merge
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  // oversampling ratio from code
  function automatic logic [15:0] osr_of(input logic [2:0] code);
    osr_of = 16'h0080 << code; // R8
  endfunction

  // mode register writes
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      mode_ff <= MODE_RST; // R3 R14
    else if (req.wr && req.addr == MODE_ADDR)
      mode_ff <= merge(mode_ff, req.wdata, MODE_WMASK);
  end

  // sticky reset flag, cleared by writing zero to mode reset bit
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reset_flag_ff <= 1'b1; // R1
    else if (req.wr && req.addr == MODE_ADDR && !req.wdata[MODE_RESET_BIT])
      reset_flag_ff <= 1'b0; // R1
  end

  // clock register, upper reserved bits read-only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      clock_ff <= CLOCK_RST; // R12
    else if (req.wr && req.addr == CLOCK_ADDR)
      clock_ff <= merge(clock_ff, req.wdata, CLOCK_WMASK); // R17
  end

  // gain, reserved and chop registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      gain_ff <= GAIN_RST;
      rsvd5_ff <= RSVD5_RST;
      chop_ff <= CHOP_RST; // R15 R16
    end
    else if (req.wr)
    begin
      if (req.addr == GAIN_ADDR)
        gain_ff <= merge(gain_ff, req.wdata, GAIN_WMASK);
      else if (req.addr == RSVD5_ADDR)
        rsvd5_ff <= req.wdata;
      else if (req.addr == CHOP_ADDR)
        chop_ff <= merge(chop_ff, req.wdata, CHOP_WMASK);
    end
  end

  // status view mirrors word length, crc type and reset flag
  always_comb
  begin
    status_w = 16'h0000;
    status_w[STAT_CRCTYPE_BIT] = mode_ff[MODE_CRCTYPE_BIT];
    status_w[STAT_RESET_BIT] = reset_flag_ff; // R13
    status_w[STAT_WLEN_LSB +: 2] = mode_ff[MODE_WLEN_LSB +: 2]; // R13
    status_w[1:0] = new_data;
  end

  // read answer, one cycle after request
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= 16'h0000;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= req.rd;
      if (req.rd)
      begin
        if (req.addr == STATUS_ADDR)
          rdata_ff <= status_w;
        else if (req.addr == MODE_ADDR)
          rdata_ff <= {mode_ff[15:11], reset_flag_ff, mode_ff[9:0]};
        else if (req.addr == CLOCK_ADDR)
          rdata_ff <= clock_ff;
        else if (req.addr == GAIN_ADDR)
          rdata_ff <= gain_ff;
        else if (req.addr == RSVD5_ADDR)
          rdata_ff <= rsvd5_ff;
        else if (req.addr == CHOP_ADDR)
          rdata_ff <= chop_ff;
        else
          rdata_ff <= 16'h0000; // unmapped reads zero
      end
    end
  end

  // decode of live register contents
  always_comb
  begin
    nxt_cfg.word_length_select = mode_ff[MODE_WLEN_LSB +: 2]; // R2
    nxt_cfg.timeout_enable = mode_ff[MODE_TIMEOUT_BIT]; // R3
    nxt_cfg.ready_pin_idle_float = mode_ff[MODE_FLOAT_BIT];
    nxt_cfg.reg_crc_enable = mode_ff[MODE_REGCRC_BIT]; // R14
    nxt_cfg.rx_crc_enable = mode_ff[MODE_RXCRC_BIT]; // R14
    nxt_cfg.crc_type_ansi = mode_ff[MODE_CRCTYPE_BIT]; // R14
    nxt_cfg.second_channel_enable = clock_ff[CLK_CH1_BIT]; // R5
    nxt_cfg.first_channel_enable = clock_ff[CLK_CH0_BIT]; // R6
    nxt_cfg.ext_clock_select = clock_ff[CLK_SEL_BIT]; // R7
    nxt_cfg.oversample_ratio_code = clock_ff[CLK_OSR_LSB +: 3]; // R8
    nxt_cfg.power_mode_code = clock_ff[CLK_PWR_LSB +: 2]; // R9
    nxt_cfg.second_channel_gain = gain_ff[GAIN1_LSB +: 3]; // R10
    nxt_cfg.first_channel_gain = gain_ff[GAIN0_LSB +: 3]; // R11
    nxt_cfg.chop_delay_code = chop_ff[CHOP_DLY_LSB +: 4]; // R15
    nxt_cfg.chop_enable = chop_ff[CHOP_EN_BIT]; // R16
  end

  // settings captured at conversion start only
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ff <= '0;
      osr_ratio_ff <= 16'h0000;
    end
    else if (conv_start)
    begin
      cfg_ff <= nxt_cfg; // R18
      osr_ratio_ff <= osr_of(nxt_cfg.oversample_ratio_code); // R8
    end
  end

  // ready pin: low on new data, else high or float
  assign any_new = |new_data;
  assign data_ready_out = ~any_new;
  assign data_ready_oe = any_new | ~mode_ff[MODE_FLOAT_BIT]; // R4

  // assertions
  clear_flag_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
    (req.wr && req.addr == MODE_ADDR && !req.wdata[MODE_RESET_BIT])
      |=> !status_w[STAT_RESET_BIT] [*2])
    else $error("reset flag not cleared");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!nrst) // R1
    $fell(reset_flag_ff) |-> $past(req.wr && req.addr == MODE_ADDR && !req.wdata[MODE_RESET_BIT]))
    else $error("reset flag dropped without write");
  wlen_mirror_a: assert property (@(posedge mclk) disable iff (!nrst) // R13
    (req.rd && req.addr == STATUS_ADDR) |=>
      rdata_ff[STAT_WLEN_LSB +: 2] == $past(mode_ff[MODE_WLEN_LSB +: 2]) &&
      rdata_ff[STAT_RESET_BIT] == $past(reset_flag_ff))
    else $error("status read does not mirror mode");
  clock_rsvd_a: assert property (@(posedge mclk) disable iff (!nrst) // R17
    clock_ff[15:10] == 6'h00)
    else $error("clock reserved bits changed");
  ready_float_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
    (!any_new && mode_ff[MODE_FLOAT_BIT]) |-> !data_ready_oe)
    else $error("ready pin driven while floating");
  ready_high_a: assert property (@(posedge mclk) disable iff (!nrst) // R4
    (!any_new && !mode_ff[MODE_FLOAT_BIT]) |-> (data_ready_oe && data_ready_out))
    else $error("ready pin not high when idle");
  cfg_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // R18
    !conv_start |=> $stable(cfg_ff))
    else $error("settings changed without conversion start");
  cfg_take_a: assert property (@(posedge mclk) disable iff (!nrst) // R18
    conv_start |=> cfg_ff.first_channel_enable == $past(clock_ff[CLK_CH0_BIT]) &&
      cfg_ff.second_channel_gain == $past(gain_ff[GAIN1_LSB +: 3]))
    else $error("settings not taken at start");
  osr_value_a: assert property (@(posedge mclk) disable iff (!nrst) // R8
    conv_start |=> osr_ratio_ff == (16'h0080 << $past(clock_ff[CLK_OSR_LSB +: 3])))
    else $error("oversampling ratio wrong");
  read_answer_a: assert property (@(posedge mclk) disable iff (!nrst) // R12
    (req.rd && req.addr == CLOCK_ADDR && !req.wr) |=> rvalid_ff && rdata_ff == $past(clock_ff))
    else $error("clock read wrong");
  write_read_c: cover property (@(posedge mclk) disable iff (!nrst)
    req.wr && req.addr == CLOCK_ADDR ##1 req.rd && req.addr == CLOCK_ADDR);
  flag_clear_c: cover property (@(posedge mclk) disable iff (!nrst) $fell(reset_flag_ff));
  float_idle_c: cover property (@(posedge mclk) disable iff (!nrst) !data_ready_oe);
  start_c: cover property (@(posedge mclk) disable iff (!nrst) conv_start && chop_ff[CHOP_EN_BIT]);
endmodule // adc_config_register_bank

// [adc_config_register_bank_tb_top.sv]
`timescale 1ns/1ps
module adc_config_register_bank_tb_top
  import adc_cfg_pkg::*;
;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t req = '0; // register request
  logic go = 1'b0; // start request to converter model
  logic [1:0] nd_req = 2'b00; // data levels to model
  logic [15:0] rdata_ff;
  logic rvalid_ff;
  logic conv_start;
  logic [1:0] new_data;
  adc_cfg_t cfg_ff;
  logic [15:0] osr_ratio_ff;
  logic data_ready_out;
  logic data_ready_oe;
  int mismatches = 0;
  int tests_run = 0;
  always #10 mclk = ~mclk;
  adc_config_register_bank i_dut (.mclk(mclk), .nrst(nrst), .req(req), .rdata_ff(rdata_ff),
    .rvalid_ff(rvalid_ff), .conv_start(conv_start), .new_data(new_data), .cfg_ff(cfg_ff),
    .osr_ratio_ff(osr_ratio_ff), .data_ready_out(data_ready_out), .data_ready_oe(data_ready_oe));
  conv_model i_conv (.mclk(mclk), .go(go), .nd_req(nd_req), .conv_start(conv_start),
    .new_data(new_data));
  // word compare
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // bit compare
  task automatic chkb(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  // one write, held for one rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    req = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    req = '0;
  endtask
  // one read; answer strobe and data one cycle later
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge mclk);
    req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge mclk);
    req = '0;
    chkb("rvalid", 1'b1, rvalid_ff);
    chk("rdata", e, rdata_ff);
  endtask
  // one conversion start through the model
  task automatic conv();
    @(negedge mclk);
    go = 1'b1;
    @(negedge mclk);
    go = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic t_reset();
    rd(CLOCK_ADDR, 16'h038e);
    rd(GAIN_ADDR, 16'h0000);
    rd(RSVD5_ADDR, 16'h0000);
    rd(CHOP_ADDR, 16'h0600);
    rd(MODE_ADDR, 16'h0510);
    rd(STATUS_ADDR, 16'h0500);
    conv();
    chk("dly", 16'h0003, {12'h000, cfg_ff.chop_delay_code});
    chkb("chop", 1'b0, cfg_ff.chop_enable);
    chkb("tmo", 1'b1, cfg_ff.timeout_enable);
    chkb("clk", 1'b1, cfg_ff.ext_clock_select);
    chk("osr", 16'h0400, osr_ratio_ff);
    chk("pwr", 16'h0002, {14'h0000, cfg_ff.power_mode_code});
    chk("wlen", 16'h0001, {14'h0000, cfg_ff.word_length_select});
    chkb("oe", 1'b1, data_ready_oe);
    chkb("pin", 1'b1, data_ready_out);
    $display("test reset done");
  endtask
  task automatic t_clock();
    // writable reserved bits 6:5 kept zero; read-only 15:10 poked to prove ignore
    wr(CLOCK_ADDR, 16'hff9f);
    rd(CLOCK_ADDR, 16'h039f);
    conv();
    chkb("ch1", 1'b1, cfg_ff.second_channel_enable);
    chkb("ch0", 1'b1, cfg_ff.first_channel_enable);
    chk("osr", 16'h4000, osr_ratio_ff);
    chk("pwr", 16'h0003, {14'h0000, cfg_ff.power_mode_code});
    wr(CLOCK_ADDR, 16'h0000);
    chkb("ch1 held", 1'b1, cfg_ff.second_channel_enable);
    conv();
    chkb("ch1", 1'b0, cfg_ff.second_channel_enable);
    chkb("ch0", 1'b0, cfg_ff.first_channel_enable);
    chkb("clk", 1'b0, cfg_ff.ext_clock_select);
    chk("osr", 16'h0080, osr_ratio_ff);
    chk("pwr", 16'h0000, {14'h0000, cfg_ff.power_mode_code});
    $display("test clock done");
  endtask
  task automatic t_gain();
    wr(GAIN_ADDR, 16'h0070);
    conv();
    chk("g1", 16'h0007, {13'h0000, cfg_ff.second_channel_gain});
    chk("g0", 16'h0000, {13'h0000, cfg_ff.first_channel_gain});
    wr(GAIN_ADDR, 16'h0005);
    conv();
    chk("g0", 16'h0005, {13'h0000, cfg_ff.first_channel_gain});
    chk("g1", 16'h0000, {13'h0000, cfg_ff.second_channel_gain});
    $display("test gain done");
  endtask
  task automatic t_mode();
    wr(MODE_ADDR, 16'h0000);
    rd(STATUS_ADDR, 16'h0000);
    // every word length code, pin set to float
    for (int c = 0; c < 4; c++)
    begin
      wr(MODE_ADDR, {6'h00, c[1:0], 8'h02});
      rd(STATUS_ADDR, {6'h00, c[1:0], 8'h00});
      conv();
      chk("wlen", {14'h0000, c[1:0]}, {14'h0000, cfg_ff.word_length_select});
    end
    wr(MODE_ADDR, 16'h3802);
    conv();
    chkb("rcrc", 1'b1, cfg_ff.reg_crc_enable);
    chkb("xcrc", 1'b1, cfg_ff.rx_crc_enable);
    chkb("ansi", 1'b1, cfg_ff.crc_type_ansi);
    chkb("tmo", 1'b0, cfg_ff.timeout_enable);
    chkb("oe", 1'b0, data_ready_oe);
    nd_req = 2'b01;
    repeat (2) @(negedge mclk);
    chkb("oe", 1'b1, data_ready_oe);
    chkb("pin", 1'b0, data_ready_out);
    // status: crc type set, flag cleared, 16-bit length, first channel ready
    rd(STATUS_ADDR, 16'h0801);
    nd_req = 2'b00;
    $display("test mode done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog well beyond the roughly ninety cycles used
  initial
  begin
    #100us;
    mismatches++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_clock();
    t_gain();
    t_mode();
    report_and_stop();
  end
endmodule // adc_config_register_bank_tb_top

// [conv_model.sv]
`timescale 1ns/1ps
// converter stand-in: start pulses and data-ready levels
module conv_model
(
  input wire logic mclk,
  input wire logic go, // start request from bench
  input wire logic [1:0] nd_req, // wanted data-available levels
  output logic conv_start, // one-cycle start pulse
  output logic [1:0] new_data // per-channel data available
);
  logic pend_ff; // start request seen at rising edge
  initial conv_start = 1'b0;
  initial new_data = 2'b00;
  // sample request on rising edge
  always_ff @(posedge mclk)
  begin
    pend_ff <= go;
  end
  // launch away from the sampling edge
  always @(negedge mclk)
  begin
    conv_start <= pend_ff;
    new_data <= nd_req;
  end
endmodule // conv_model
